// *** rtl/pasl_top.sv ***
// strap capture and lamp drive for the shared address bit 2/3/4 pins
// assumes pins, hw_rst and status inputs are synchronous to clk_sys;
// rst is the power-on reset, hw_rst the hardware reset request
`timescale 1ns/1ps
`default_nettype none

module pasl_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hw_rst,
  input wire logic link_up,
  input wire logic rx_activity,
  input wire pasl_pkg::pasl_pins_s pin_in,
  output pasl_pkg::pasl_pins_s pin_out,
  output pasl_pkg::pasl_pins_s pin_oe,
  output logic [pasl_pkg::ADDR_W-1:0] phy_addr_hi,
  output logic addr_valid
);

  pasl_pkg::pasl_state_e state_q;
  pasl_pkg::pasl_state_e state_d;
  logic [pasl_pkg::ADDR_W-1:0] addr_q;
  logic [pasl_pkg::ADDR_W-1:0] oe_q;
  logic [pasl_pkg::ADDR_W-1:0] lamp_q;
  logic valid_q;
  logic lamp_phase_d;

  // phase sequencing: strap while hw_rst is high, lamps once it drops
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pasl_pkg::ST_STRAP: begin
        if (!hw_rst) begin
          state_d = pasl_pkg::ST_LAMP;
        end
      end
      pasl_pkg::ST_LAMP: begin
        if (hw_rst) begin
          state_d = pasl_pkg::ST_STRAP;
        end
      end
      default: begin
        state_d = pasl_pkg::ST_STRAP;
      end
    endcase
  end

  assign lamp_phase_d = (state_d == pasl_pkg::ST_LAMP);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= pasl_pkg::ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  // strap sampling in reset
  // address follows the pins every strap cycle; the last one is kept
  // level to bit mapping
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_q <= pasl_pkg::ADDR_RST;
    end else if (state_q == pasl_pkg::ST_STRAP) begin
      addr_q <= pin_in;
    end
  end

  // pins turn to outputs
  // drivers open on the same edge that takes the final strap sample
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oe_q <= pasl_pkg::OE_RST;
    end else if (lamp_phase_d) begin
      oe_q <= pasl_pkg::OE_ALL;
    end else begin
      oe_q <= pasl_pkg::OE_RST;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lamp_q <= pasl_pkg::LAMP_RST;
    end else if (lamp_phase_d) begin
      lamp_q[pasl_pkg::POS_LINK2] <= link_up;
      lamp_q[pasl_pkg::POS_TX3] <= link_up;
      lamp_q[pasl_pkg::POS_RX4] <= rx_activity;
    end else begin
      lamp_q <= pasl_pkg::LAMP_RST;
    end
  end

  // address usable once strapping is over
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= lamp_phase_d;
    end
  end

  assign pin_out = lamp_q;
  assign pin_oe = oe_q;
  assign phy_addr_hi = addr_q;
  assign addr_valid = valid_q;

  a_strap_no_drive:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_STRAP) |-> (pin_oe == pasl_pkg::OE_RST))
  else $error("shared pin driven during strap phase");

  // final strap sample becomes the address
  a_strap_capture:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_STRAP && !hw_rst) |=>
      (phy_addr_hi == $past(pin_in) && addr_valid))
  else $error("address does not match sampled strap levels");

  // outputs enabled one edge after hardware reset drops
  a_oe_after_reset:
  assert property (@(posedge clk_sys) disable iff (rst)
    (hw_rst ##1 !hw_rst) |=> (pin_oe == pasl_pkg::OE_ALL))
  else $error("pins not turned to outputs after reset");

  // link lamp on bit 2 pin
  a_link_lamp:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_d == pasl_pkg::ST_LAMP) |=>
      (pin_out.addr2_link_lamp_pin == $past(link_up)))
  else $error("bit 2 lamp does not follow link status");

  a_bit3_polarity:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_d == pasl_pkg::ST_LAMP && !link_up) |=>
      (pin_oe.addr3_tx_lamp_pin && !pin_out.addr3_tx_lamp_pin))
  else $error("bit 3 pin asserted without a link");

  // receive lamp on bit 4 pin
  a_rx_lamp:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_d == pasl_pkg::ST_LAMP) |=>
      (pin_out.addr4_rx_lamp_pin == $past(rx_activity)))
  else $error("bit 4 lamp does not follow receive activity");

  a_addr_frozen:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_LAMP && !hw_rst)[*2] |->
      $stable(phy_addr_hi))
  else $error("latched address changed outside reset");

  a_hw_reset_strap:
  assert property (@(posedge clk_sys) disable iff (rst)
    hw_rst |=> (state_q == pasl_pkg::ST_STRAP && !addr_valid))
  else $error("hardware reset did not return to strap phase");

  a_state_onehot:
  assert property (@(posedge clk_sys) disable iff (rst)
    $onehot(state_q))
  else $error("phase register left its legal codes");

  a_strap_lamps_dark:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_STRAP) |-> (pin_out == pasl_pkg::LAMP_RST))
  else $error("lamp level shown during strap phase");

  // every strap edge copies the pads
  a_strap_follow:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_STRAP) |=>
      (phy_addr_hi == $past(pin_in)))
  else $error("address bits differ from strap levels");

  // all pads driven in lamp phase
  a_lamp_drive_on:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_LAMP) |->
      (pin_oe == pasl_pkg::OE_ALL && addr_valid))
  else $error("pads not driven in lamp phase");

  a_hw_reset_release:
  assert property (@(posedge clk_sys) disable iff (rst)
    hw_rst |=>
      (pin_oe == pasl_pkg::OE_RST && pin_out == pasl_pkg::LAMP_RST))
  else $error("pads still driven after hardware reset");

  // bit 3 pin asserted with a link
  a_bit3_link_on:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_d == pasl_pkg::ST_LAMP && link_up) |=>
      (pin_oe.addr3_tx_lamp_pin && pin_out.addr3_tx_lamp_pin))
  else $error("bit 3 pin not asserted with a valid link");

  // bit 4 pin driven as a lamp
  a_rx_lamp_drive:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_d == pasl_pkg::ST_LAMP) |=> pin_oe.addr4_rx_lamp_pin)
  else $error("bit 4 pin not driven after reset");

  // lamp phase pad levels never reach the address
  a_addr_held:
  assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == pasl_pkg::ST_LAMP) |=> $stable(phy_addr_hi))
  else $error("address moved with lamp levels");

endmodule : pasl_top

`default_nettype wire

// *** rtl/pasl_pkg.sv ***
// constants and carrier types for the address strap / lamp pin block
// assumes one core clock; pins are three-signal (in, out, oe) at the ports
package pasl_pkg;

  // address bits covered by this block: bits 2, 3 and 4
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned ADDR_W = 3;

  // field positions inside the pin bundle
  localparam int unsigned POS_LINK2 = 0;
  localparam int unsigned POS_TX3 = 1;
  localparam int unsigned POS_RX4 = 2;

  // reset values, plus the all-pins drive enable
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [ADDR_W-1:0] OE_RST = 3'h0;
  localparam logic [ADDR_W-1:0] LAMP_RST = 3'h0;
  localparam logic [ADDR_W-1:0] OE_ALL = 3'h7;

  // one signal per shared pin; bit order matches address bits 4..2
  typedef struct packed {
    logic addr4_rx_lamp_pin;
    logic addr3_tx_lamp_pin;
    logic addr2_link_lamp_pin;
  } pasl_pins_s;

  // strap phase while any reset is active, lamp phase afterwards
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_LAMP = 2'b10
  } pasl_state_e;

endpackage : pasl_pkg

// *** verif/pasl_board.sv ***
// board model: strap pulls and lamps
// assumes strap levels come from the bench
`timescale 1ns/1ps
`default_nettype none
module pasl_board (
  input wire logic [2:0] strap,
  input wire pasl_pkg::pasl_pins_s pin_out,
  input wire pasl_pkg::pasl_pins_s pin_oe,
  output pasl_pkg::pasl_pins_s pin_in
);
  // released pad sits at its pull level
  assign pin_in = (pin_out & pin_oe) | (strap & ~pin_oe);
endmodule : pasl_board
`default_nettype wire

// *** verif/phy_address_strap_led_pins_tb.sv ***
// self-checking bench for the strap and lamp pins
// assumes pasl_board stands for pulls and lamps
`timescale 1ns/1ps
`default_nettype none
module phy_address_strap_led_pins_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hw_rst = 1'b1;
  logic link_up = 1'b0;
  logic rx_activity = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [2:0] lamp_q = 3'h0;
  logic [2:0] exp_addr = 3'h0;
  logic av_q = 1'b0;
  logic ev_q = 1'b0;
  logic [2:0] exp_q[$];
  integer seed = 32;
  integer fails = 0;
  integer check_count = 0;
  pasl_pkg::pasl_pins_s pin_in, pin_out, pin_oe;
  logic [2:0] phy_addr_hi;
  logic addr_valid;
  always #5 clk_sys = ~clk_sys;
  pasl_top dut (.clk_sys(clk_sys), .rst(rst), .hw_rst(hw_rst),
    .link_up(link_up), .rx_activity(rx_activity), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .phy_addr_hi(phy_addr_hi),
    .addr_valid(addr_valid));
  pasl_board board (.strap(strap), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    lamp_q <= {rx_activity, link_up, link_up};
  end
  // valid expected one edge after hw_rst is seen low
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_q <= 1'b0;
    end else begin
      ev_q <= !hw_rst;
    end
  end
  // outputs settle by the falling edge
  always @(negedge clk_sys) begin
    if (!rst) begin
      check({2'h0, addr_valid}, {2'h0, ev_q});
      if (ev_q && !av_q) begin
        check(3'(exp_q.size() != 0), 3'h1);
        if (exp_q.size() != 0) exp_addr = exp_q.pop_front();
      end
      if (ev_q) begin
        check(phy_addr_hi, exp_addr);
        check(pin_oe, pasl_pkg::OE_ALL);
        check(pin_out, lamp_q);
      end else begin
        check(pin_oe, pasl_pkg::OE_RST);
        check(pin_out, pasl_pkg::LAMP_RST);
      end
    end
    av_q = ev_q;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      hw_rst <= 1'b1;
      strap <= 3'($random(seed));
      repeat (i % 3 + 1) @(posedge clk_sys);
      hw_rst <= 1'b0;
      exp_q.push_back(strap);
      repeat (12) begin
        @(posedge clk_sys);
        {rx_activity, link_up} <= 2'($random(seed));
      end
    end
    // power-on reset in mid-run re-straps with hw_rst low
    rst <= 1'b1;
    strap <= 3'($random(seed));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    exp_q.push_back(strap);
    repeat (12) begin
      @(posedge clk_sys);
      {rx_activity, link_up} <= 2'($random(seed));
    end
    @(posedge clk_sys);
    test_done();
  end
  initial begin
    #5000;
    fails++;
    $display("unexpected at %0t: run did not finish in time", $time);
    test_done();
  end
endmodule : phy_address_strap_led_pins_tb
`default_nettype wire
